// *** rtl/atm_pkg.sv ***
// Constants shared by the converter front-end mode-control block
package atm_pkg;
  // ----------------------------------------
  // Command word layout
  // ----------------------------------------
  localparam int CMD_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 12;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CMD_BITS = 5'h10;
  // ----------------------------------------
  // Address codes
  // ----------------------------------------
  localparam logic [3:0] ADR_ENABLE_16 = 4'h0;
  localparam logic [3:0] ADR_AUX_DAC_ONE = 4'h1;
  localparam logic [3:0] ADR_AUX_DAC_TWO = 4'h2;
  localparam logic [3:0] ADR_AUX_DAC_THREE = 4'h3;
  localparam logic [3:0] ADR_INPHASE_TRIM = 4'h4;
  localparam logic [3:0] ADR_QUADRATURE_TRIM = 4'h5;
  localparam logic [3:0] ADR_COMMON_LEVEL = 4'h6;
  localparam logic [3:0] ADR_AUX_ADC = 4'h7;
  localparam logic [3:0] ADR_ENABLE_8 = 4'h8;
  // ----------------------------------------
  // Enable word field positions and setting field widths
  // ----------------------------------------
  localparam int POS_DIR_SOURCE = 3;
  localparam int POS_AUX_DAC_ONE_OFF = 4;
  localparam int POS_AUX_DAC_TWO_OFF = 5;
  localparam int POS_AUX_DAC_THREE_OFF = 6;
  localparam int POS_AUX_ADC_OFF = 9;
  localparam int TRIM_W = 6;
  localparam int COMMON_W = 2;
  // ----------------------------------------
  // Control nibble codes
  // ----------------------------------------
  localparam logic [3:0] NIB_EXT_ONE = 4'h3;
  localparam logic [3:0] NIB_EXT_TWO = 4'h4;
  localparam logic [3:0] NIB_EXT_THREE = 4'h5;
  localparam logic [3:0] NIB_EXT_FOUR = 4'h6;
  localparam logic [3:0] NIB_SER_SLOW_RX = 4'hB;
  localparam logic [3:0] NIB_SER_SLOW_TX = 4'hC;
  localparam logic [3:0] NIB_SER_FAST_RX = 4'hD;
  localparam logic [3:0] NIB_SER_FAST_TX = 4'hE;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] RST_NIBBLE = NIB_EXT_TWO;
  localparam logic [11:0] RST_DAC_VALUE = 12'h000;
  localparam logic [5:0] RST_TRIM = 6'h00;
  localparam logic [1:0] RST_COMMON = 2'h0;
  // Serial-chosen direction at power-up
  localparam logic RST_SER_TX = 1'b0;
endpackage : atm_pkg

// *** rtl/atm_shift_in.sv ***
// Serial command word receiver, MSB first
`timescale 1ns/100ps
`default_nettype none
module atm_shift_in
  import atm_pkg::*;
#(
  parameter int WIDTH = CMD_W
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_sel_n,
  input wire logic i_sclk_rise,
  input wire logic i_sdata,
  output logic o_word_valid,
  output logic [WIDTH-1:0] o_word
);
  typedef struct packed {
    logic [WIDTH-1:0] shift;
    logic [CNT_W-1:0] count;
    logic valid;
    logic [WIDTH-1:0] word;
  } atm_sh_t;
  atm_sh_t st_r;
  atm_sh_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = 1'b0;
    if (i_sel_n) begin
      st_nxt.count = '0;
    end else if (i_sclk_rise) begin
      st_nxt.shift = {st_r.shift[WIDTH-2:0], i_sdata};
      if (st_r.count == CMD_BITS - 5'h01) begin
        st_nxt.valid = 1'b1;
        st_nxt.word = {st_r.shift[WIDTH-2:0], i_sdata};
        st_nxt.count = '0;
      end else begin
        st_nxt.count = st_r.count + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_word_valid = st_r.valid;
  assign o_word = st_r.word;

  full_word_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_word_valid |-> $past(st_r.count) == CMD_BITS - 5'h01)
    else $error("Word issued before sixteen bits");
endmodule : atm_shift_in
`default_nettype wire

// *** rtl/atm_mode_decode.sv ***
// Converter power and bus direction from control nibble and direction pin
`timescale 1ns/100ps
`default_nettype none
module atm_mode_decode
  import atm_pkg::*;
(
  input wire logic [3:0] i_nibble,
  input wire logic i_ser_tx,
  input wire logic i_dir_pin,
  output logic o_rx_on,
  output logic o_tx_on,
  output logic o_tx_dir
);
  logic tx;
  always_comb begin
    tx = i_nibble[POS_DIR_SOURCE] ? i_ser_tx : i_dir_pin;
    o_tx_dir = tx;
    o_rx_on = 1'b1;
    o_tx_on = 1'b1;
    case (i_nibble)
      NIB_EXT_ONE: o_rx_on = ~tx;
      NIB_EXT_TWO: o_tx_on = tx;
      NIB_EXT_THREE: begin
        o_rx_on = ~tx;
        o_tx_on = tx;
      end
      NIB_EXT_FOUR: o_rx_on = 1'b1;
      NIB_SER_SLOW_RX, NIB_SER_SLOW_TX: begin
        o_rx_on = ~tx;
        o_tx_on = tx;
      end
      NIB_SER_FAST_RX, NIB_SER_FAST_TX: o_rx_on = 1'b1;
      // Power-management codes lie outside this block; cores off
      default: begin
        o_rx_on = 1'b0;
        o_tx_on = 1'b0;
      end
    endcase
  end
endmodule : atm_mode_decode
`default_nettype wire

// *** rtl/atm_mode_ctrl.sv ***
// Top of the converter front-end mode-control block
`timescale 1ns/100ps
`default_nettype none
module atm_mode_ctrl
  import atm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_sel_n,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_dir_pin,
  output logic o_rx_core_on,
  output logic o_tx_core_on,
  output logic o_bus_tx_dir,
  output logic [2:0] o_aux_dac_on,
  output logic o_aux_adc_on,
  output logic [DATA_W-1:0] o_aux_dac_one_value,
  output logic [DATA_W-1:0] o_aux_dac_two_value,
  output logic [DATA_W-1:0] o_aux_dac_three_value,
  output logic [TRIM_W-1:0] o_inphase_trim,
  output logic [TRIM_W-1:0] o_quadrature_trim,
  output logic [COMMON_W-1:0] o_common_level,
  output logic o_aux_adc_start,
  output logic [DATA_W-1:0] o_aux_adc_setup
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic sclk_d;
    logic [3:0] nibble;
    logic ser_tx;
    logic [2:0] aux_dac_off;
    logic aux_adc_off;
    logic [DATA_W-1:0] dac_one;
    logic [DATA_W-1:0] dac_two;
    logic [DATA_W-1:0] dac_three;
    logic [TRIM_W-1:0] i_trim;
    logic [TRIM_W-1:0] q_trim;
    logic [COMMON_W-1:0] common;
    logic adc_start;
    logic [DATA_W-1:0] adc_setup;
    logic rx_on;
    logic tx_on;
    logic tx_dir;
  } atm_state_t;
  atm_state_t st_r;
  atm_state_t st_nxt;

  logic word_valid;
  logic [CMD_W-1:0] word;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic rx_on_c;
  logic tx_on_c;
  logic tx_dir_c;

  assign addr = word[ADDR_W-1:0];
  assign data = word[CMD_W-1:ADDR_W];

  // ----------------------------------------
  // Serial receiver
  // ----------------------------------------
  atm_shift_in #(
    .WIDTH(CMD_W)
  ) u_shift (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_sel_n(i_sel_n),
    .i_sclk_rise(i_sclk & ~st_r.sclk_d),
    .i_sdata(i_sdata),
    .o_word_valid(word_valid),
    .o_word(word)
  );

  // ----------------------------------------
  // Mode decode from stored nibble
  // ----------------------------------------
  atm_mode_decode u_decode (
    .i_nibble(st_r.nibble),
    .i_ser_tx(st_r.ser_tx),
    .i_dir_pin(i_dir_pin),
    .o_rx_on(rx_on_c),
    .o_tx_on(tx_on_c),
    .o_tx_dir(tx_dir_c)
  );

  // ----------------------------------------
  // Command apply
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_d = i_sclk;
    st_nxt.adc_start = 1'b0;
    st_nxt.rx_on = rx_on_c;
    st_nxt.tx_on = tx_on_c;
    st_nxt.tx_dir = tx_dir_c;
    if (word_valid) begin
      case (addr)
        ADR_ENABLE_16: begin
          st_nxt.nibble = data[3:0];
          st_nxt.aux_dac_off[0] = data[POS_AUX_DAC_ONE_OFF];
          st_nxt.aux_dac_off[1] = data[POS_AUX_DAC_TWO_OFF];
          st_nxt.aux_dac_off[2] = data[POS_AUX_DAC_THREE_OFF];
          st_nxt.aux_adc_off = data[POS_AUX_ADC_OFF];
          // Reserved top bits ignored; host keeps them zero
          // Serial direction from nibble
          if (data[POS_DIR_SOURCE]) begin
            st_nxt.ser_tx = (data[3:0] == NIB_SER_SLOW_TX) || (data[3:0] == NIB_SER_FAST_TX);
          end
        end
        ADR_ENABLE_8: begin
          st_nxt.nibble = data[3:0];
          if (data[POS_DIR_SOURCE]) begin
            st_nxt.ser_tx = (data[3:0] == NIB_SER_SLOW_TX) || (data[3:0] == NIB_SER_FAST_TX);
          end
        end
        ADR_AUX_DAC_ONE: st_nxt.dac_one = data;
        ADR_AUX_DAC_TWO: st_nxt.dac_two = data;
        ADR_AUX_DAC_THREE: st_nxt.dac_three = data;
        ADR_INPHASE_TRIM: st_nxt.i_trim = data[TRIM_W-1:0];
        ADR_QUADRATURE_TRIM: st_nxt.q_trim = data[TRIM_W-1:0];
        ADR_COMMON_LEVEL: st_nxt.common = data[COMMON_W-1:0];
        ADR_AUX_ADC: begin
          st_nxt.adc_start = 1'b1;
          st_nxt.adc_setup = data;
        end
        default: st_nxt.adc_start = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= '0;
      st_r.nibble <= RST_NIBBLE;
      st_r.ser_tx <= RST_SER_TX;
      st_r.dac_one <= RST_DAC_VALUE;
      st_r.dac_two <= RST_DAC_VALUE;
      st_r.dac_three <= RST_DAC_VALUE;
      st_r.i_trim <= RST_TRIM;
      st_r.q_trim <= RST_TRIM;
      st_r.common <= RST_COMMON;
      st_r.rx_on <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_rx_core_on = st_r.rx_on;
  assign o_tx_core_on = st_r.tx_on;
  assign o_bus_tx_dir = st_r.tx_dir;
  assign o_aux_dac_on = ~st_r.aux_dac_off;
  assign o_aux_adc_on = ~st_r.aux_adc_off;
  assign o_aux_dac_one_value = st_r.dac_one;
  assign o_aux_dac_two_value = st_r.dac_two;
  assign o_aux_dac_three_value = st_r.dac_three;
  assign o_inphase_trim = st_r.i_trim;
  assign o_quadrature_trim = st_r.q_trim;
  assign o_common_level = st_r.common;
  assign o_aux_adc_start = st_r.adc_start;
  assign o_aux_adc_setup = st_r.adc_setup;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  ext_one_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_EXT_ONE |=> o_rx_core_on == ~o_bus_tx_dir && o_tx_core_on)
    else $error("Setting one power wrong");
  ext_two_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_EXT_TWO |=> o_rx_core_on && o_tx_core_on == o_bus_tx_dir)
    else $error("Setting two power wrong");
  ext_three_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_EXT_THREE |=> o_rx_core_on != o_tx_core_on)
    else $error("Setting three power wrong");
  ext_four_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_EXT_FOUR |=> o_rx_core_on && o_tx_core_on)
    else $error("Setting four power wrong");
  pin_follow_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !st_r.nibble[POS_DIR_SOURCE] |=> o_bus_tx_dir == $past(i_dir_pin))
    else $error("Direction does not follow pin");
  slow_tx_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_SER_SLOW_TX && st_r.ser_tx |=> o_bus_tx_dir && !o_rx_core_on)
    else $error("Serial slow transmit wrong");
  fast_both_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_SER_FAST_RX |=> o_rx_core_on && o_tx_core_on && !o_bus_tx_dir)
    else $error("Serial fast receive wrong");
  dac_store_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_AUX_DAC_TWO |=> o_aux_dac_two_value == $past(data))
    else $error("Aux DAC value not stored");
  adc_start_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_aux_adc_start |-> $past(word_valid) && $past(addr) == ADR_AUX_ADC)
    else $error("Spurious conversion start");
  dac_power_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_ENABLE_16
    |=> o_aux_dac_on[0] == ~$past(data[POS_AUX_DAC_ONE_OFF]))
    else $error("Aux DAC power bit wrong");

  // ----------------------------------------
  // Per-setting and per-register checks
  // ----------------------------------------
  ext_one_rx_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_EXT_ONE && !i_dir_pin |=> o_rx_core_on && o_tx_core_on && !o_bus_tx_dir)
    else $error("Setting one receive wrong");
  ext_one_tx_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_EXT_ONE && i_dir_pin |=> !o_rx_core_on && o_tx_core_on && o_bus_tx_dir)
    else $error("Setting one transmit wrong");
  ext_two_rx_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_EXT_TWO && !i_dir_pin |=> o_rx_core_on && !o_tx_core_on && !o_bus_tx_dir)
    else $error("Setting two receive wrong");
  ext_three_tx_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_EXT_THREE && i_dir_pin |=> !o_rx_core_on && o_tx_core_on && o_bus_tx_dir)
    else $error("Setting three transmit wrong");
  slow_rx_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_SER_SLOW_RX |=> o_rx_core_on && !o_tx_core_on && !o_bus_tx_dir)
    else $error("Serial slow receive wrong");
  fast_tx_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble == NIB_SER_FAST_TX |=> o_rx_core_on && o_tx_core_on && o_bus_tx_dir)
    else $error("Serial fast transmit wrong");
  serial_dir_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_r.nibble[POS_DIR_SOURCE] |=> o_bus_tx_dir == $past(st_r.ser_tx))
    else $error("Serial direction follows pin");
  dac_one_store_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_AUX_DAC_ONE |=> o_aux_dac_one_value == $past(data))
    else $error("Aux DAC one value not stored");
  dac_three_store_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_AUX_DAC_THREE |=> o_aux_dac_three_value == $past(data))
    else $error("Aux DAC three value not stored");
  inphase_trim_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_INPHASE_TRIM |=> o_inphase_trim == $past(data[TRIM_W-1:0]))
    else $error("Inphase trim not stored");
  quad_trim_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_QUADRATURE_TRIM |=> o_quadrature_trim == $past(data[TRIM_W-1:0]))
    else $error("Quadrature trim not stored");
  common_store_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_COMMON_LEVEL |=> o_common_level == $past(data[COMMON_W-1:0]))
    else $error("Common level not stored");
  adc_pulse_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_AUX_ADC
    |=> o_aux_adc_start && o_aux_adc_setup == $past(data))
    else $error("Conversion start missing");
  start_one_cycle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_aux_adc_start |=> !o_aux_adc_start)
    else $error("Conversion start stretched");
  dac_power_two_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_ENABLE_16
    |=> o_aux_dac_on[1] == ~$past(data[POS_AUX_DAC_TWO_OFF]))
    else $error("Aux DAC two power bit wrong");
  dac_power_three_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_ENABLE_16
    |=> o_aux_dac_on[2] == ~$past(data[POS_AUX_DAC_THREE_OFF]))
    else $error("Aux DAC three power bit wrong");
  adc_power_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_ENABLE_16
    |=> o_aux_adc_on == ~$past(data[POS_AUX_ADC_OFF]))
    else $error("Aux ADC power bit wrong");
  short_keeps_aux_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_ENABLE_8 |=> $stable(o_aux_dac_on) && $stable(o_aux_adc_on))
    else $error("Short word changed aux power");
  short_nibble_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_ENABLE_8 |=> st_r.nibble == $past(data[3:0]))
    else $error("Short word nibble not stored");
  wide_nibble_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    word_valid && addr == ADR_ENABLE_16 |=> st_r.nibble == $past(data[3:0]))
    else $error("Wide word nibble not stored");
  settings_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !word_valid |=> $stable(o_aux_dac_one_value) && $stable(o_aux_dac_two_value)
      && $stable(o_aux_dac_three_value) && $stable(o_inphase_trim)
      && $stable(o_quadrature_trim) && $stable(o_common_level))
    else $error("Stored setting changed without a word");
  aux_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !word_valid |=> $stable(o_aux_dac_on) && $stable(o_aux_adc_on) && $stable(st_r.nibble))
    else $error("Power setting changed without a word");
endmodule : atm_mode_ctrl
`default_nettype wire

// *** testbench/atm_host_model.sv ***
// Host controller model driving the serial port and direction pin
`timescale 1ns/100ps
`default_nettype none
module atm_host_model
  import atm_pkg::*;
(
  input wire logic i_clock,
  output var logic o_sel_n,
  output var logic o_sclk,
  output var logic o_sdata,
  output var logic o_dir_pin
);
  initial begin
    o_sel_n = 1'b1;
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_dir_pin = 1'b0;
  end

  // Sends the first n bits, MSB first; fewer than 16 makes a partial word
  task automatic send_bits(input logic [CMD_W-1:0] w, input int n);
    @(posedge i_clock);
    o_sel_n <= 1'b0;
    for (int i = CMD_W - 1; i > CMD_W - 1 - n; i--) begin
      @(posedge i_clock);
      o_sclk <= 1'b0;
      o_sdata <= w[i];
      @(posedge i_clock);
      o_sclk <= 1'b1;
    end
    @(posedge i_clock);
    o_sclk <= 1'b0;
    o_sel_n <= 1'b1;
    // Released data line must not keep showing the last bit
    o_sdata <= ~o_sdata;
  endtask : send_bits

  task automatic send_word(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    logic [DATA_W-1:0] d;
    d = data;
    if (addr == ADR_ENABLE_16) d[11:10] = 2'b00;
    send_bits({d, addr}, CMD_W);
  endtask : send_word

  task automatic set_dir(input logic v);
    @(posedge i_clock);
    o_dir_pin <= v;
  endtask : set_dir
endmodule : atm_host_model
`default_nettype wire

// *** testbench/test_afe_txrx_mode_control.sv ***
// Self-checking bench for the converter front-end mode-control block
`timescale 1ns/100ps
`default_nettype none
module test_afe_txrx_mode_control;
  import atm_pkg::*;
  logic i_clock;
  logic i_sys_rst;
  logic sel_n, sclk, sdata, dir_pin;
  logic rx_on, tx_on, tx_dir, adc_on, adc_start;
  logic [2:0] dac_on;
  logic [11:0] v1, v2, v3, adc_setup;
  logic [5:0] itrim, qtrim;
  logic [1:0] common;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_start = 0;
  localparam logic [3:0] NIBS [8] = '{NIB_EXT_ONE, NIB_EXT_TWO, NIB_EXT_THREE, NIB_EXT_FOUR,
    NIB_SER_SLOW_RX, NIB_SER_SLOW_TX, NIB_SER_FAST_RX, NIB_SER_FAST_TX};

  atm_host_model u_host (.i_clock(i_clock), .o_sel_n(sel_n), .o_sclk(sclk), .o_sdata(sdata),
    .o_dir_pin(dir_pin));
  atm_mode_ctrl u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sel_n(sel_n),
    .i_sclk(sclk), .i_sdata(sdata), .i_dir_pin(dir_pin), .o_rx_core_on(rx_on),
    .o_tx_core_on(tx_on), .o_bus_tx_dir(tx_dir), .o_aux_dac_on(dac_on),
    .o_aux_adc_on(adc_on), .o_aux_dac_one_value(v1), .o_aux_dac_two_value(v2),
    .o_aux_dac_three_value(v3), .o_inphase_trim(itrim), .o_quadrature_trim(qtrim),
    .o_common_level(common), .o_aux_adc_start(adc_start), .o_aux_adc_setup(adc_setup));

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  // Counts cycles the start pulse is high, so a stretched pulse shows too
  always @(posedge i_clock) begin
    if (adc_start === 1'b1) n_start++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check_value(input string name, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check_value

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask : settle

  // Expected {rx_on, tx_on, tx_dir}
  function automatic logic [2:0] exp_mode(input logic [3:0] n, input logic p);
    case (n)
      NIB_EXT_ONE: return p ? 3'b011 : 3'b110;
      NIB_EXT_TWO: return p ? 3'b111 : 3'b100;
      NIB_EXT_THREE: return p ? 3'b011 : 3'b100;
      NIB_EXT_FOUR: return {2'b11, p};
      NIB_SER_SLOW_RX: return 3'b100;
      NIB_SER_SLOW_TX: return 3'b011;
      NIB_SER_FAST_RX: return 3'b110;
      default: return 3'b111;
    endcase
  endfunction : exp_mode

  task automatic stop_test();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    stop_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    settle(2);
    check_value("reset mode", 12'({rx_on, tx_on, tx_dir}), 12'h004);
    check_value("reset aux", 12'({dac_on, adc_on}), 12'h00F);
    check_value("reset dac one", v1, 12'h000);
    check_value("reset trims", 12'({itrim, qtrim}), 12'h000);
    // Alternate wide and short enable words across the mode codes
    for (int k = 0; k < 8; k++) begin
      u_host.send_word(k[0] ? ADR_ENABLE_8 : ADR_ENABLE_16, {8'h00, NIBS[k]});
      for (int p = 0; p < 2; p++) begin
        u_host.set_dir(p[0]);
        settle(3);
        check_value("mode", 12'({rx_on, tx_on, tx_dir}), 12'(exp_mode(NIBS[k], p[0])));
      end
    end
    u_host.set_dir(1'b0);
    // Power-management code: both cores off, direction from pin
    u_host.send_word(ADR_ENABLE_8, 12'h000);
    settle(3);
    check_value("cores off", 12'({rx_on, tx_on, tx_dir}), 12'h000);
    for (int k = 0; k < 8; k++) begin
      u_host.send_word(ADR_ENABLE_16, {2'b00, k[0], 2'b00, k[2:0], NIB_EXT_TWO});
      settle(3);
      check_value("aux dac on", 12'(dac_on), 12'({~k[2:0]}));
      check_value("aux adc on", 12'(adc_on), 12'({~k[0]}));
    end
    // Short word must leave the aux power bits alone
    u_host.send_word(ADR_ENABLE_8, 12'h004);
    settle(3);
    check_value("aux kept", 12'({dac_on, adc_on}), 12'h000);
    check_value("short mode", 12'({rx_on, tx_on, tx_dir}), 12'h004);
    u_host.send_word(ADR_AUX_DAC_ONE, 12'hFFF);
    u_host.send_word(ADR_AUX_DAC_TWO, 12'h5A3);
    u_host.send_word(ADR_AUX_DAC_THREE, 12'h801);
    u_host.send_word(ADR_INPHASE_TRIM, 12'hFBF);
    u_host.send_word(ADR_QUADRATURE_TRIM, 12'h020);
    u_host.send_word(ADR_COMMON_LEVEL, 12'hFFE);
    // Partial word and unmapped codes must change nothing
    u_host.send_bits({12'h123, ADR_AUX_DAC_ONE}, 12);
    u_host.send_word(4'h9, 12'h456);
    u_host.send_word(4'hF, 12'h789);
    settle(3);
    check_value("dac one", v1, 12'hFFF);
    check_value("dac two", v2, 12'h5A3);
    check_value("dac three", v3, 12'h801);
    check_value("inphase trim", 12'(itrim), 12'h03F);
    check_value("quadrature trim", 12'(qtrim), 12'h020);
    check_value("common level", 12'(common), 12'h002);
    check_value("no start yet", 12'(n_start), 12'h000);
    u_host.send_word(ADR_AUX_ADC, 12'h3A5);
    settle(4);
    check_value("start pulses", 12'(n_start), 12'h001);
    check_value("adc setup", adc_setup, 12'h3A5);
    check_value("dac one kept", v1, 12'hFFF);
    stop_test();
  end
endmodule : test_afe_txrx_mode_control
`default_nettype wire
